/* logic/quad_pot_serial_control.sv */
// Serial slave front end and register core of a quad digital pot
`timescale 1ns/1ns
module quad_pot_serial_control #(
   parameter logic [3:0] DEVICE_TYPE = 4'h9, // Arbitrary device type value
   parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic pause_input_n_i,
   input wire logic nonvolatile_write_lock_n_i,
   input wire logic [1:0] strap_address_inputs_i,
   output logic so_o,
   output logic so_oe_o,
   output logic write_in_progress_o,
   output logic [pot_pkg::POT_COUNT*pot_pkg::TAP_COUNT-1:0] wiper_tap_output_o
);
   localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

   // Link side sequence states
   typedef enum logic [2:0] {L_ID, L_INSTR, L_DATA, L_INCDEC, L_DONE} link_state_t;

   // ---------------- Core side storage ----------------
   logic [5:0] wiper_mem_r [pot_pkg::POT_COUNT]; // Volatile wiper positions
   logic [5:0] slot_mem_r [pot_pkg::POT_COUNT][pot_pkg::SLOT_COUNT]; // Stored settings
   logic wip_r; // Nonvolatile write underway
   logic [CNT_W-1:0] nv_cnt_r; // Remaining write cycles
   logic armed_r; // Select seen high since reset
   logic pu_load_r; // One-shot preset recall after reset

   // Synchronisers into the core clock
   logic cs_s1_r, cs_s2_r, cs_s3_r;
   logic wp_s1_r, wp_s2_r;
   logic [1:0] strap_s1_r, strap_s2_r;
   logic tgl_s1_r, tgl_s2_r, tgl_s3_r;

   // Staged slot write, waiting for deselect
   logic pend_r;
   logic pend_glb_r;
   logic pend_copy_r; // Copy from wiper rather than host data
   logic [1:0] pend_slot_r;
   logic [1:0] pend_pot_r;
   logic [5:0] pend_data_r;

   // ---------------- Link side state ----------------
   logic lrst; // Link reset: power reset or deselect
   link_state_t lstate_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] byte_in; // Byte including the bit on the wire now
   logic byte_last; // This edge completes a byte
   logic [3:0] ins_op_r;
   logic [1:0] ins_slot_r;
   logic [1:0] ins_pot_r;
   logic id_ok;
   // Command handed to the core, fields held until the next toggle
   logic issue;
   logic [3:0] cmd_op_r;
   logic [1:0] cmd_slot_r;
   logic [1:0] cmd_pot_r;
   logic [5:0] cmd_data_r;
   logic cmd_up_r;
   logic cmd_tgl_r;
   // Transmit path on the falling edge
   logic [7:0] tx_sh_r;
   logic tx_act_r;
   logic [7:0] rd_byte;
   logic wip_l1_r, wip_l2_r; // Write flag synchronised on the link clock

   // Core side events
   logic cmd_evt, cs_rise, cs_fall, commit;

   // Opcode classes
   function automatic logic is_read(input logic [3:0] op);
      is_read = (op == pot_pkg::OP_RD_WIPER) || (op == pot_pkg::OP_RD_SLOT) ||
                (op == pot_pkg::OP_RD_STATUS);
   endfunction : is_read

   function automatic logic is_write(input logic [3:0] op);
      is_write = (op == pot_pkg::OP_WR_WIPER) || (op == pot_pkg::OP_WR_SLOT);
   endfunction : is_write

   function automatic logic is_xfr(input logic [3:0] op);
      is_xfr = (op == pot_pkg::OP_SLOT_TO_WIPER) || (op == pot_pkg::OP_WIPER_TO_SLOT) ||
               (op == pot_pkg::OP_GLB_SLOT_TO_WIPER) || (op == pot_pkg::OP_GLB_WIPER_TO_SLOT);
   endfunction : is_xfr

   function automatic logic is_nv(input logic [3:0] op);
      is_nv = (op == pot_pkg::OP_WR_SLOT) || (op == pot_pkg::OP_WIPER_TO_SLOT) ||
              (op == pot_pkg::OP_GLB_WIPER_TO_SLOT);
   endfunction : is_nv

   // =================== Link clock domain ===================

   // Deselect clears the whole sequence; a short glitch on select does the same
   assign lrst = rst_i | cs_n_i;
   assign byte_in = {shift_r[6:0], si_i};
   assign byte_last = (bit_cnt_r == pot_pkg::BIT_LAST);

   // Straps and the armed flag only change outside frames, so they are steady here
   assign id_ok = armed_r && (byte_in[7:pot_pkg::ID_TYPE_LSB] == DEVICE_TYPE) &&
                  (byte_in[pot_pkg::ID_ADDR_LSB +: 2] == strap_s2_r);

   // Bit counter and input shifter; a low pause freezes both
   always_ff @(posedge sck_i or posedge lrst) begin
      if (lrst) begin
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
      end else if (pause_input_n_i) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shift_r <= byte_in;
      end
   end

   // Sequence state machine
   always_ff @(posedge sck_i or posedge lrst) begin
      if (lrst) begin
         lstate_r <= L_ID;
         ins_op_r <= 4'h0;
         ins_slot_r <= 2'h0;
         ins_pot_r <= 2'h0;
      end else if (pause_input_n_i) begin
         case (lstate_r)
            L_ID: begin
               // Mismatch leaves the device idle until deselect
               if (byte_last) begin
                  lstate_r <= id_ok ? L_INSTR : L_DONE;
               end
            end
            L_INSTR: begin
               if (byte_last) begin
                  ins_op_r <= byte_in[pot_pkg::OP_LSB +: 4];
                  ins_slot_r <= byte_in[pot_pkg::SLOT_LSB +: 2];
                  ins_pot_r <= byte_in[pot_pkg::POT_LSB +: 2];
                  if (is_read(byte_in[7:4]) || is_write(byte_in[7:4])) begin
                     lstate_r <= L_DATA;
                  end else if (byte_in[7:4] == pot_pkg::OP_INC_DEC) begin
                     lstate_r <= L_INCDEC;
                  end else begin
                     // Transfers end here; unknown opcodes are dropped
                     lstate_r <= L_DONE;
                  end
               end
            end
            L_DATA: begin
               if (byte_last) begin
                  lstate_r <= L_DONE;
               end
            end
            L_INCDEC: begin
               // Open-ended: every clock is one step until deselect
               lstate_r <= L_INCDEC;
            end
            L_DONE: begin
               lstate_r <= L_DONE;
            end
            default: begin
               lstate_r <= L_DONE;
            end
         endcase
      end
   end

   // A command goes to the core only once its last bit has arrived
   always_comb begin
      issue = 1'b0;
      case (lstate_r)
         L_INSTR: issue = byte_last && is_xfr(byte_in[7:4]);
         L_DATA: issue = byte_last && is_write(ins_op_r);
         L_INCDEC: issue = 1'b1;
         default: issue = 1'b0;
      endcase
   end

   // Command holding registers with a toggle; deselect must not clear them
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_op_r <= 4'h0;
         cmd_slot_r <= 2'h0;
         cmd_pot_r <= 2'h0;
         cmd_data_r <= 6'h00;
         cmd_up_r <= 1'b0;
         cmd_tgl_r <= 1'b0;
      end else if (!cs_n_i && pause_input_n_i && issue) begin
         cmd_op_r <= (lstate_r == L_INSTR) ? byte_in[7:4] : ins_op_r;
         cmd_slot_r <= (lstate_r == L_INSTR) ? byte_in[3:2] : ins_slot_r;
         cmd_pot_r <= (lstate_r == L_INSTR) ? byte_in[1:0] : ins_pot_r;
         cmd_data_r <= byte_in[5:0];
         cmd_up_r <= si_i; // High steps up, low steps down
         cmd_tgl_r <= ~cmd_tgl_r;
      end
   end

   // Write flag brought onto the link clock; settles during the first two bytes
   always_ff @(negedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         wip_l1_r <= 1'b0;
         wip_l2_r <= 1'b0;
      end else begin
         wip_l1_r <= wip_r;
         wip_l2_r <= wip_l1_r;
      end
   end

   // Answer byte: data in the low bits (six, or one for status), other bits zero
   always_comb begin
      case (ins_op_r)
         pot_pkg::OP_RD_WIPER: rd_byte = {2'h0, wiper_mem_r[ins_pot_r]};
         pot_pkg::OP_RD_SLOT: rd_byte = {2'h0, slot_mem_r[ins_pot_r][ins_slot_r]};
         pot_pkg::OP_RD_STATUS: rd_byte = {7'h00, wip_l2_r};
         default: rd_byte = 8'h00;
      endcase
   end

   // Transmit shifter on the falling edge, most significant bit first
   always_ff @(negedge sck_i or posedge lrst) begin
      if (lrst) begin
         tx_sh_r <= 8'h00;
         tx_act_r <= 1'b0;
      end else if (pause_input_n_i) begin
         if (lstate_r == L_DATA && is_read(ins_op_r) && !tx_act_r) begin
            tx_sh_r <= rd_byte;
            tx_act_r <= 1'b1;
         end else if (tx_act_r) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   // Drive only while answering; shared data wire stays free otherwise
   assign so_o = tx_sh_r[7];
   assign so_oe_o = tx_act_r && (lstate_r == L_DATA) && pause_input_n_i && !cs_n_i;

   // =================== Core clock domain ===================

   // Two-stage synchronisers; third stages only feed edge detectors
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Select starts low, so arming needs a real high level after reset
         cs_s1_r <= 1'b0;
         cs_s2_r <= 1'b0;
         cs_s3_r <= 1'b0;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
         strap_s1_r <= 2'h0;
         strap_s2_r <= 2'h0;
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n_i;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         wp_s1_r <= nonvolatile_write_lock_n_i;
         wp_s2_r <= wp_s1_r;
         strap_s1_r <= strap_address_inputs_i;
         strap_s2_r <= strap_s1_r;
         tgl_s1_r <= cmd_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   assign cmd_evt = tgl_s2_r ^ tgl_s3_r;
   // Gated by arming, so the first high level after reset is no false rise
   assign cs_rise = cs_s2_r && !cs_s3_r && armed_r;
   assign cs_fall = !cs_s2_r && cs_s3_r;
   // Commit refused while locked or while an earlier write still runs
   assign commit = cs_rise && pend_r && wp_s2_r && !wip_r;

   // Bus is ignored until select has been seen high after reset
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         armed_r <= 1'b0;
      end else if (cs_s2_r) begin
         armed_r <= 1'b1;
      end
   end

   // Preset recall happens once, on the first edge after reset
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pu_load_r <= 1'b1;
      end else begin
         pu_load_r <= 1'b0;
      end
   end

   // Wiper positions: the only writers are recall, write, transfer and step
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int p = 0; p < pot_pkg::POT_COUNT; p++) begin
            wiper_mem_r[p] <= pot_pkg::WIPER_RESET;
         end
      end else if (pu_load_r) begin
         for (int p = 0; p < pot_pkg::POT_COUNT; p++) begin
            wiper_mem_r[p] <= slot_mem_r[p][0];
         end
      end else if (cmd_evt) begin
         case (cmd_op_r)
            pot_pkg::OP_WR_WIPER: begin
               wiper_mem_r[cmd_pot_r] <= cmd_data_r;
            end
            pot_pkg::OP_SLOT_TO_WIPER: begin
               wiper_mem_r[cmd_pot_r] <= slot_mem_r[cmd_pot_r][cmd_slot_r];
            end
            pot_pkg::OP_GLB_SLOT_TO_WIPER: begin
               for (int p = 0; p < pot_pkg::POT_COUNT; p++) begin
                  wiper_mem_r[p] <= slot_mem_r[p][cmd_slot_r];
               end
            end
            pot_pkg::OP_INC_DEC: begin
               // Steps stop at the array ends instead of wrapping
               if (cmd_up_r && wiper_mem_r[cmd_pot_r] != pot_pkg::MAX_POS) begin
                  wiper_mem_r[cmd_pot_r] <= wiper_mem_r[cmd_pot_r] + 6'h01;
               end else if (!cmd_up_r && wiper_mem_r[cmd_pot_r] != pot_pkg::MIN_POS) begin
                  wiper_mem_r[cmd_pot_r] <= wiper_mem_r[cmd_pot_r] - 6'h01;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Staged slot write: a new frame drops it, a completed command loads it
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         pend_glb_r <= 1'b0;
         pend_copy_r <= 1'b0;
         pend_slot_r <= 2'h0;
         pend_pot_r <= 2'h0;
         pend_data_r <= 6'h00;
      end else if (cmd_evt && is_nv(cmd_op_r)) begin
         pend_r <= 1'b1;
         pend_glb_r <= (cmd_op_r == pot_pkg::OP_GLB_WIPER_TO_SLOT);
         pend_copy_r <= (cmd_op_r != pot_pkg::OP_WR_SLOT);
         pend_slot_r <= cmd_slot_r;
         pend_pot_r <= cmd_pot_r;
         pend_data_r <= cmd_data_r;
      end else if (cs_rise || cs_fall) begin
         pend_r <= 1'b0;
      end
   end

   // Stored settings change only when a staged write commits
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int p = 0; p < pot_pkg::POT_COUNT; p++) begin
            for (int s = 0; s < pot_pkg::SLOT_COUNT; s++) begin
               slot_mem_r[p][s] <= pot_pkg::SLOT_RESET;
            end
         end
      end else if (commit) begin
         for (int p = 0; p < pot_pkg::POT_COUNT; p++) begin
            if (pend_glb_r || pend_pot_r == 2'(p)) begin
               slot_mem_r[p][pend_slot_r] <= pend_copy_r ? wiper_mem_r[p] : pend_data_r;
            end
         end
      end
   end

   // Write time counter; the flag stays up for the full programming time
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wip_r <= 1'b0;
         nv_cnt_r <= '0;
      end else if (commit) begin
         wip_r <= 1'b1;
         nv_cnt_r <= CNT_W'(NV_WRITE_CYCLES - 1);
      end else if (wip_r) begin
         if (nv_cnt_r == '0) begin
            wip_r <= 1'b0;
         end else begin
            nv_cnt_r <= nv_cnt_r - CNT_W'(1);
         end
      end
   end

   assign write_in_progress_o = wip_r;

   // One tap decoder per pot
   for (genvar g = 0; g < pot_pkg::POT_COUNT; g++) begin : g_tap
      tap_decoder #(
         .POS_W(pot_pkg::POS_W),
         .TAP_COUNT(pot_pkg::TAP_COUNT)
      ) u_tap (
         .core_clk_i(core_clk_i),
         .rst_i(rst_i),
         .pos_i(wiper_mem_r[g]),
         .tap_sel_o(wiper_tap_output_o[g*pot_pkg::TAP_COUNT +: pot_pkg::TAP_COUNT])
      );
   end
endmodule : quad_pot_serial_control

/* logic/pot_pkg.sv */
// Shared constants for the quad pot serial control block
package pot_pkg;
   // Array geometry
   localparam int POT_COUNT = 4;
   localparam int SLOT_COUNT = 4;
   localparam int POS_W = 6;
   localparam int TAP_COUNT = 64;
   localparam logic [5:0] MAX_POS = 6'h3f;
   localparam logic [5:0] MIN_POS = 6'h00;
   // Identification byte fields
   localparam int ID_TYPE_LSB = 4;
   localparam int ID_ADDR_LSB = 0;
   // Instruction byte fields
   localparam int OP_LSB = 4;
   localparam int SLOT_LSB = 2;
   localparam int POT_LSB = 0;
   // Opcodes
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'ha;
   localparam logic [3:0] OP_RD_SLOT = 4'hb;
   localparam logic [3:0] OP_WR_SLOT = 4'hc;
   localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hd;
   localparam logic [3:0] OP_WIPER_TO_SLOT = 4'he;
   localparam logic [3:0] OP_GLB_SLOT_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GLB_WIPER_TO_SLOT = 4'h8;
   localparam logic [3:0] OP_RD_STATUS = 4'h5;
   localparam logic [3:0] OP_INC_DEC = 4'h2;
   // Values after reset, and the last bit index
   localparam logic [5:0] SLOT_RESET = 6'h00;
   localparam logic [5:0] WIPER_RESET = 6'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Nonvolatile write time
   localparam int CORE_CLK_KHZ = 50000;
   localparam int NV_WRITE_TIME_MS = 10;
   localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * CORE_CLK_KHZ;
endpackage : pot_pkg

/* logic/tap_decoder.sv */
// One-hot tap switch select for one pot, registered
`timescale 1ns/1ns
module tap_decoder #(
   parameter int POS_W = 6,
   parameter int TAP_COUNT = 64
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [POS_W-1:0] pos_i,
   output logic [TAP_COUNT-1:0] tap_sel_o
);
   // Single set bit, shifted to the selected tap
   localparam logic [TAP_COUNT-1:0] TAP_ONE = TAP_COUNT'(1);

   // Registered decode: exactly one switch is on, also during reset
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tap_sel_o <= TAP_ONE << pot_pkg::WIPER_RESET;
      end else begin
         tap_sel_o <= TAP_ONE << pos_i;
      end
   end
endmodule : tap_decoder

/* bench/quad_pot_serial_control_asserts.sv */
// Port-level concurrent checks for the quad pot serial control block
`timescale 1ns/1ns
module quad_pot_serial_control_asserts #(
   parameter int NV_WRITE_CYCLES = 50
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic pause_input_n_i,
   input wire logic nonvolatile_write_lock_n_i,
   input wire logic [1:0] strap_address_inputs_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   input wire logic write_in_progress_o,
   input wire logic [pot_pkg::POT_COUNT*pot_pkg::TAP_COUNT-1:0] wiper_tap_output_o
);
   logic [31:0] wip_cnt_r; // Cycles the current write has been busy
   // Length of each write; cleared while idle so every write is timed afresh
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wip_cnt_r <= 32'h0;
      end else if (write_in_progress_o) begin
         wip_cnt_r <= wip_cnt_r + 32'h1;
      end else begin
         wip_cnt_r <= 32'h0;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   chk_one_tap_each:
      assert property ($onehot(wiper_tap_output_o[0 +: 64])
         && $onehot(wiper_tap_output_o[64 +: 64])
         && $onehot(wiper_tap_output_o[128 +: 64]) && $onehot(wiper_tap_output_o[192 +: 64]))
      else $error("tap select not one-hot");
   chk_quiet_deselect:
      assert property (cs_n_i |-> !so_oe_o) else $error("output driven while deselected");
   chk_quiet_pause:
      assert property (!pause_input_n_i |-> !so_oe_o) else $error("output driven while paused");
   chk_shift_falling:
      assert property (so_oe_o && sck_i |-> $stable(so_o))
      else $error("output moved on high clock");
   chk_drive_on_fall:
      assert property ($rose(so_oe_o) |-> !sck_i && !cs_n_i)
      else $error("drive began off the fall");
   chk_commit_deselect:
      assert property ($rose(write_in_progress_o) |-> $past(cs_n_i) && cs_n_i)
      else $error("write began while selected");
   chk_lock_refuses:
      assert property ($rose(write_in_progress_o) |-> $past(nonvolatile_write_lock_n_i))
      else $error("write began while locked");
   chk_write_length:
      assert property ($fell(write_in_progress_o) |-> wip_cnt_r == NV_WRITE_CYCLES)
      else $error("write time wrong");
   chk_taps_idle:
      assert property (cs_n_i [*8] |=> $stable(wiper_tap_output_o))
      else $error("wiper moved while idle");
   // Main scenarios reached
   cover property ($rose(write_in_progress_o));
   cover property ($rose(so_oe_o));
   cover property (!pause_input_n_i && !cs_n_i);
endmodule : quad_pot_serial_control_asserts

bind quad_pot_serial_control quad_pot_serial_control_asserts #(
   .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_u (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
   .pause_input_n_i(pause_input_n_i), .nonvolatile_write_lock_n_i(nonvolatile_write_lock_n_i),
   .strap_address_inputs_i(strap_address_inputs_i), .so_o(so_o), .so_oe_o(so_oe_o),
   .write_in_progress_o(write_in_progress_o), .wiper_tap_output_o(wiper_tap_output_o));

/* bench/spi_host_model.sv */
// Host bus master model for the serial link
`timescale 1ns/1ns
module spi_host_model (
   input wire logic so_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   output logic pause_n_o
);
   localparam int HALF = 80; // Half of the 160 ns link period
   // Clock parked low outside frames, deselected, no pause
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      pause_n_o = 1'b1;
   end
   // Frame of n bits, first bit first; pauses before bit pz; bits 16..23 come back
   task automatic frame(input int n, input logic [39:0] tx, input int pz,
         output logic [7:0] rx);
      rx = 8'h00;
      #37;
      cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si_o = tx[i];
         if (n - 1 - i == pz) begin
            // Pause moves 1 ns off the fall so it never races that edge
            #1;
            pause_n_o = 1'b0;
            // Clock keeps running while paused; the device must ignore it
            repeat (2) begin
               #HALF;
               sck_o = 1'b1;
               #HALF;
               sck_o = 1'b0;
            end
            #1;
            pause_n_o = 1'b1;
         end
         #HALF;
         sck_o = 1'b1;
         if (n - 1 - i >= 16) rx = {rx[6:0], so_i};
         #HALF;
         sck_o = 1'b0;
      end
      #HALF;
      cs_n_o = 1'b1;
      si_o = ~si_o; // Idle data must not look like a held bit
      #250;
   endtask : frame
   // Select held low through a reset, so no falling edge is ever seen
   task automatic grab();
      cs_n_o = 1'b0;
   endtask : grab
endmodule : spi_host_model

/* bench/test_quad_pot_serial_control.sv */
// Self-checking bench for the quad pot serial control block
`timescale 1ns/1ns
`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module test_quad_pot_serial_control;
   localparam int NV_W = 400; // Short write time keeps the run brief
   localparam logic [3:0] DTYPE = 4'h9; // Arbitrary device type value
   logic core_clk_i, rst_i, lock_n, sck, cs_n, si, pause_n, so, so_oe, write_in_progress_flag;
   logic [1:0] strap, p, s;
   logic [255:0] taps;
   logic [31:0] seed = 32'h661773fc; // Fixed seed keeps runs repeatable
   logic [5:0] wiper [4]; // Expected wipers
   logic [5:0] slot [4][4]; // Expected slots by pot, slot
   logic [7:0] rx, idflip;
   int mismatches, total_checks, cycles;
   quad_pot_serial_control #(.DEVICE_TYPE(DTYPE), .NV_WRITE_CYCLES(NV_W)) dut_u (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .pause_input_n_i(pause_n), .nonvolatile_write_lock_n_i(lock_n),
      .strap_address_inputs_i(strap), .so_o(so), .so_oe_o(so_oe),
      .write_in_progress_o(write_in_progress_flag), .wiper_tap_output_o(taps));
   // A released output reads inverted, so data taken without enable fails
   spi_host_model host_u (.so_i(so_oe ? so : ~so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
      .pause_n_o(pause_n));
   // Core clock, 20 ns
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // Hang guard
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // One-hot taps expected from the tracked wipers
   function automatic logic [255:0] exp_taps();
      logic [255:0] t = 256'h0;
      for (int g = 0; g < 4; g++) t[g * 64 + int'(wiper[g])] = 1'b1;
      return t;
   endfunction : exp_taps
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Framed command of n bits, then settle time for the core
   task automatic run(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] pt,
         input logic [7:0] d, input int n, input int pz = -1);
      logic [39:0] tx;
      tx = {16'h0, {DTYPE, 2'b00, strap} ^ idflip, op, sl, pt, d} >> (24 - n);
      host_u.frame(n, tx, pz, rx);
      repeat (10) @(negedge core_clk_i);
   endtask : run
   task automatic wr_wiper(input logic [1:0] pt, input logic [5:0] v);
      wiper[pt] = v;
      run(pot_pkg::OP_WR_WIPER, 2'b00, pt, {2'b00, v}, 24);
   endtask : wr_wiper
   task automatic rd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] pt,
         input logic [7:0] e, input int pz = -1);
      run(op, sl, pt, 8'h00, 24, pz);
      `CHECK("read byte", e, rx)
   endtask : rd
   task automatic wait_idle();
      for (int i = 0; i < NV_W + 20 && write_in_progress_flag !== 1'b0; i++) @(negedge core_clk_i);
      `CHECK("busy", 1'b0, write_in_progress_flag)
   endtask : wait_idle
   initial begin
      rst_i = 1'b1;
      lock_n = 1'b1;
      idflip = 8'h00;
      strap = 2'(rnd());
      foreach (slot[g, k]) slot[g][k] = 6'h00;
      foreach (wiper[g]) wiper[g] = 6'h00;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (10) @(negedge core_clk_i);
      `CHECK("taps", exp_taps(), taps)
      // Direct writes, read back with a pause inside each read
      for (int g = 0; g < 4; g++) wr_wiper(2'(g), 6'(rnd()));
      `CHECK("taps", exp_taps(), taps)
      for (int g = 0; g < 4; g++) begin
         rd(pot_pkg::OP_RD_WIPER, 2'b00, 2'(g), {2'b00, wiper[g]}, 14 + 2 * g);
      end
      // Wrong type, wrong address, early deselect change nothing
      idflip = 8'h30;
      run(pot_pkg::OP_WR_WIPER, 2'b00, 2'b00, {2'b00, ~wiper[0]}, 24);
      idflip = 8'h01;
      run(pot_pkg::OP_WR_WIPER, 2'b00, 2'b00, {2'b00, ~wiper[0]}, 24);
      idflip = 8'h00;
      run(pot_pkg::OP_WR_WIPER, 2'b00, 2'b01, {2'b00, ~wiper[1]}, 20);
      `CHECK("taps", exp_taps(), taps)
      // Slot writes: busy, status, read back
      for (int k = 0; k < 4; k++) begin
         p = 2'(rnd());
         s = 2'(k);
         slot[p][s] = 6'(rnd());
         run(pot_pkg::OP_WR_SLOT, s, p, {2'b00, slot[p][s]}, 24);
         `CHECK("busy", 1'b1, write_in_progress_flag)
         rd(pot_pkg::OP_RD_STATUS, 2'b00, 2'b00, 8'h01);
         wait_idle();
         rd(pot_pkg::OP_RD_SLOT, s, p, {2'b00, slot[p][s]});
      end
      rd(pot_pkg::OP_RD_STATUS, 2'b00, 2'b00, 8'h00);
      // Locked slot write is dropped
      lock_n = 1'b0;
      run(pot_pkg::OP_WR_SLOT, 2'b01, 2'b11, {2'b00, ~slot[3][1]}, 24);
      `CHECK("busy", 1'b0, write_in_progress_flag)
      lock_n = 1'b1;
      rd(pot_pkg::OP_RD_SLOT, 2'b01, 2'b11, {2'b00, slot[3][1]});
      // Wiper to slot, single then global
      p = 2'(rnd());
      s = 2'(rnd());
      slot[p][s] = wiper[p];
      run(pot_pkg::OP_WIPER_TO_SLOT, s, p, 8'h00, 16);
      wait_idle();
      rd(pot_pkg::OP_RD_SLOT, s, p, {2'b00, slot[p][s]});
      s = s + 2'b01;
      for (int g = 0; g < 4; g++) slot[g][s] = wiper[g];
      run(pot_pkg::OP_GLB_WIPER_TO_SLOT, s, 2'b00, 8'h00, 16);
      wait_idle();
      rd(pot_pkg::OP_RD_SLOT, s, 2'b10, {2'b00, slot[2][s]});
      // Fresh wipers, then slot to wiper, single then global
      for (int g = 0; g < 4; g++) wr_wiper(2'(g), 6'(rnd()));
      wiper[p] = slot[p][s];
      run(pot_pkg::OP_SLOT_TO_WIPER, s, p, 8'h00, 16);
      `CHECK("taps", exp_taps(), taps)
      s = 2'(rnd());
      for (int g = 0; g < 4; g++) wiper[g] = slot[g][s];
      run(pot_pkg::OP_GLB_SLOT_TO_WIPER, s, 2'b00, 8'h00, 16);
      `CHECK("taps", exp_taps(), taps)
      // Six steps each way, saturating at both ends
      for (int k = 0; k < 4; k++) begin
         wr_wiper(2'(k), k[0] ? 6'h3c : 6'h03);
         for (int i = 0; i < 6; i++) begin
            if (k[0] ^ k[1]) begin
               if (wiper[k] != pot_pkg::MAX_POS) wiper[k] = wiper[k] + 6'h01;
            end else if (wiper[k] != pot_pkg::MIN_POS) wiper[k] = wiper[k] - 6'h01;
         end
         run(pot_pkg::OP_INC_DEC, 2'b00, 2'(k), {8{k[0] ^ k[1]}}, 22);
      end
      `CHECK("taps", exp_taps(), taps)
      // Second reset with select held low: select never seen high, so the frame is ignored
      rst_i = 1'b1;
      host_u.grab();
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      foreach (wiper[g]) wiper[g] = 6'h00;
      run(pot_pkg::OP_WR_WIPER, 2'b00, 2'b00, 8'h2a, 24);
      `CHECK("taps", exp_taps(), taps)
      wr_wiper(2'b00, 6'h2a);
      `CHECK("taps", exp_taps(), taps)
      give_verdict();
   end
endmodule : test_quad_pot_serial_control
